// ===== hdl/aw_pkg.sv
package aw_pkg;
    // timing
    localparam int CLK_NS      = 20;
    localparam int BSY_MAX_NS  = 400;
    localparam int BSY_MAX_CYC = BSY_MAX_NS / CLK_NS;
    localparam logic [2:0] PREP_CYC = 3'h2;

    // command codes
    localparam logic [7:0] CMD_TRANSLATE = 8'h87;
    localparam logic [7:0] CMD_WEARLEVEL = 8'hf5;
    localparam logic [7:0] CMD_WRBUF     = 8'he8;
    localparam logic [7:0] CMD_WRDMA     = 8'hca;
    localparam logic [7:0] CMD_WRMULT    = 8'hc5;
    localparam logic [7:0] CMD_SETMULT   = 8'hc6;
    localparam logic [7:0] CMD_SETFEAT   = 8'hef;
    localparam logic [7:0] FEAT_8BIT_ON  = 8'h01;
    localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
    localparam logic [7:0] MAX_BLOCK     = 8'h01;
    localparam logic [7:0] ERR_ABRT      = 8'h04;
    localparam logic [7:0] ERR_MEDIA     = 8'h40;
    localparam logic [7:0] HEAD_FIXED    = 8'ha0;
    localparam logic [7:0] WORD_LAST     = 8'hff;
    localparam logic [8:0] SECT_MAX      = 9'h100;

    // task file indices
    localparam logic [2:0] TF_DATA = 3'h0;
    localparam logic [2:0] TF_ERR  = 3'h1;
    localparam logic [2:0] TF_CNT  = 3'h2;
    localparam logic [2:0] TF_SEC  = 3'h3;
    localparam logic [2:0] TF_CYLL = 3'h4;
    localparam logic [2:0] TF_CYLH = 3'h5;
    localparam logic [2:0] TF_HEAD = 3'h6;
    localparam logic [2:0] TF_CMD  = 3'h7;

    // host register map
    localparam logic [7:0] HREG_STATUS  = 8'h00;
    localparam logic [7:0] HREG_DMA     = 8'h04;
    localparam logic [2:0] HREG_TF_PAGE = 3'h1;
    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;

    typedef enum logic [1:0] {
        DS_IDLE  = 2'b00,
        DS_PREP  = 2'b01,
        DS_XFER  = 2'b11,
        DS_MEDIA = 2'b10
    } aw_dstate_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_LINK = 2'b01,
        HS_WAIT = 2'b11,
        HS_RESP = 2'b10
    } aw_hstate_t;
endpackage

// ===== hdl/aw_link_if.sv
`timescale 1ns/1ps
interface aw_link_if;
    logic [2:0]  tfAddr;
    logic [15:0] tfWrData;
    logic        tfWr;
    logic        tfRd;
    logic        dmack;
    logic [15:0] tfRdData;
    logic        intrq;
    logic        dmareq;

    modport dev (
        input  tfAddr, tfWrData, tfWr, tfRd, dmack,
        output tfRdData, intrq, dmareq
    );
    modport host (
        output tfAddr, tfWrData, tfWr, tfRd, dmack,
        input  tfRdData, intrq, dmareq
    );
endinterface

// ===== hdl/aw_dev_end.sv
// Chosen here: the sector buffer and its read port; the address map and AXI4-Lite port are in aw_host_end.
`timescale 1ns/1ps
module aw_dev_end
    import aw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    aw_link_if.dev           link,
    input  wire logic [7:0]  bufRdAddr,
    output logic      [15:0] bufRdData,
    output logic             sectorValid,
    output logic      [27:0] sectorLba,
    input  wire logic        mediaErr
);
    typedef struct packed {
        aw_dstate_t  st;
        logic [7:0]  cmd;
        logic [7:0]  feat;
        logic [7:0]  err;
        logic [7:0]  cnt;
        logic [7:0]  sec;
        logic [7:0]  cyll;
        logic [7:0]  cylh;
        logic [7:0]  head;
        logic        bsy;
        logic        drq;
        logic        errF;
        logic        intrq;
        logic        multEn;
        logic        eightBit;
        logic [8:0]  remain;
        logic [7:0]  word;
        logic [2:0]  prep;
        logic        secDone;
        logic [15:0] rdData;
        logic [15:0] bufRd;
    } aw_dreg_t;

    aw_dreg_t    r_ff;
    aw_dreg_t    nxt_r;
    logic [15:0] secBuf [0:255];
    logic        bufWe;
    logic        finish;
    logic        abort;
    logic        take;
    logic        isDma;
    logic [27:0] lba;
    logic [27:0] nxtLba;
    logic [7:0]  status;

    assign lba    = {r_ff.head[3:0], r_ff.cylh, r_ff.cyll, r_ff.sec};
    assign nxtLba = lba + 28'h1;
    assign isDma  = (r_ff.cmd == CMD_WRDMA);
    assign status = {r_ff.bsy, 1'b1, 1'b0, 1'b1, r_ff.drq, 2'b00, r_ff.errF};
    // data strobes: DMA words need dmack, PIO words must not carry it
    assign take   = (r_ff.st == DS_XFER) && link.tfWr &&
                    (isDma ? link.dmack : (!link.dmack && link.tfAddr == TF_DATA));
    assign bufWe  = take;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.secDone = 1'b0;
        nxt_r.bufRd = secBuf[bufRdAddr];
        finish = 1'b0;
        abort = 1'b0;
        if (link.tfRd) begin
            unique case (link.tfAddr)
                TF_DATA: nxt_r.rdData = 16'h0000;
                TF_ERR:  nxt_r.rdData = {8'h00, r_ff.err};
                TF_CNT:  nxt_r.rdData = {8'h00, r_ff.cnt};
                TF_SEC:  nxt_r.rdData = {8'h00, r_ff.sec};
                TF_CYLL: nxt_r.rdData = {8'h00, r_ff.cyll};
                TF_CYLH: nxt_r.rdData = {8'h00, r_ff.cylh};
                TF_HEAD: nxt_r.rdData = {8'h00, r_ff.head};
                TF_CMD: begin
                    nxt_r.rdData = {8'h00, status};
                    nxt_r.intrq = 1'b0;
                end
            endcase
        end
        unique case (r_ff.st)
            DS_IDLE: begin
                if (link.tfWr && !link.dmack) begin
                    unique case (link.tfAddr)
                        TF_DATA: ;
                        TF_ERR:  nxt_r.feat = link.tfWrData[7:0];
                        TF_CNT:  nxt_r.cnt = link.tfWrData[7:0];
                        TF_SEC:  nxt_r.sec = link.tfWrData[7:0];
                        TF_CYLL: nxt_r.cyll = link.tfWrData[7:0];
                        TF_CYLH: nxt_r.cylh = link.tfWrData[7:0];
                        TF_HEAD: nxt_r.head = link.tfWrData[7:0];
                        TF_CMD: begin
                            nxt_r.cmd = link.tfWrData[7:0];
                            nxt_r.bsy = 1'b1;
                            nxt_r.intrq = 1'b0;
                            nxt_r.errF = 1'b0;
                            nxt_r.err = 8'h00;
                            nxt_r.prep = PREP_CYC;
                            nxt_r.st = DS_PREP;
                        end
                    endcase
                end
            end
            DS_PREP: begin
                nxt_r.prep = r_ff.prep - 3'h1;
                if (r_ff.prep == 3'h0) begin
                    nxt_r.word = 8'h00;
                    nxt_r.remain = (r_ff.cnt == 8'h00) ? SECT_MAX : {1'b0, r_ff.cnt};
                    unique case (r_ff.cmd)
                        CMD_TRANSLATE, CMD_WEARLEVEL: begin
                            nxt_r.cnt = 8'h00;
                            finish = 1'b1;
                        end
                        CMD_SETMULT: begin
                            if (r_ff.cnt == 8'h00) begin
                                nxt_r.multEn = 1'b0;
                            end else if (r_ff.cnt == MAX_BLOCK) begin
                                nxt_r.multEn = 1'b1;
                            end else begin
                                nxt_r.multEn = 1'b0;
                                abort = 1'b1;
                            end
                            finish = 1'b1;
                        end
                        CMD_SETFEAT: begin
                            if (r_ff.feat == FEAT_8BIT_ON) begin
                                nxt_r.eightBit = 1'b1;
                            end else if (r_ff.feat == FEAT_8BIT_OFF) begin
                                nxt_r.eightBit = 1'b0;
                            end
                            finish = 1'b1;
                        end
                        CMD_WRBUF: begin
                            nxt_r.remain = 9'h001;
                            nxt_r.bsy = 1'b0;
                            nxt_r.drq = 1'b1;
                            nxt_r.st = DS_XFER;
                        end
                        CMD_WRDMA: begin
                            if (r_ff.eightBit) begin
                                abort = 1'b1;
                            end else begin
                                nxt_r.bsy = 1'b0;
                                nxt_r.drq = 1'b1;
                                nxt_r.st = DS_XFER;
                            end
                        end
                        CMD_WRMULT: begin
                            if (!r_ff.multEn) begin
                                abort = 1'b1;
                            end else begin
                                nxt_r.bsy = 1'b0;
                                nxt_r.drq = 1'b1;
                                nxt_r.st = DS_XFER;
                            end
                        end
                        default: abort = 1'b1;
                    endcase
                end
            end
            DS_XFER: begin
                if (take) begin
                    nxt_r.word = r_ff.word + 8'h01;
                    if (r_ff.word == WORD_LAST) begin
                        nxt_r.drq = 1'b0;
                        nxt_r.bsy = 1'b1;
                        if (r_ff.cmd == CMD_WRBUF) begin
                            finish = 1'b1;
                        end else begin
                            nxt_r.secDone = 1'b1;
                            nxt_r.st = DS_MEDIA;
                        end
                    end
                end
            end
            DS_MEDIA: begin
                if (mediaErr) begin
                    // address still names the failing sector
                    nxt_r.err = ERR_MEDIA;
                    nxt_r.errF = 1'b1;
                    nxt_r.cnt = r_ff.remain[7:0];
                    finish = 1'b1;
                end else begin
                    nxt_r.remain = r_ff.remain - 9'h001;
                    nxt_r.cnt = 8'(r_ff.remain - 9'h001);
                    if (r_ff.remain == 9'h001) begin
                        finish = 1'b1;
                    end else begin
                        {nxt_r.head[3:0], nxt_r.cylh, nxt_r.cyll, nxt_r.sec} = nxtLba;
                        nxt_r.bsy = 1'b0;
                        nxt_r.drq = 1'b1;
                        nxt_r.st = DS_XFER;
                        if (r_ff.cmd == CMD_WRMULT) begin
                            nxt_r.intrq = 1'b1;
                        end
                    end
                end
            end
        endcase
        if (abort) begin
            nxt_r.err = ERR_ABRT;
            nxt_r.errF = 1'b1;
            finish = 1'b1;
        end
        if (finish) begin
            nxt_r.bsy = 1'b0;
            nxt_r.drq = 1'b0;
            nxt_r.intrq = 1'b1;
            nxt_r.st = DS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // sector buffer, no reset needed
    always_ff @(posedge clk) begin
        if (bufWe) begin
            secBuf[r_ff.word] <= link.tfWrData;
        end
    end

    assign link.tfRdData = r_ff.rdData;
    assign link.intrq    = r_ff.intrq;
    assign link.dmareq   = (r_ff.st == DS_XFER) && isDma;
    assign bufRdData     = r_ff.bufRd;
    assign sectorValid   = r_ff.secDone;
    assign sectorLba     = lba;
endmodule

// ===== hdl/aw_host_end.sv
`timescale 1ns/1ps
module aw_host_end
    import aw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready,
    aw_link_if.host          link
);
    typedef struct packed {
        aw_hstate_t  st;
        logic        awGot;
        logic        wGot;
        logic        isRd;
        logic        rdWait;
        logic [7:0]  addr;
        logic [15:0] data;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic        bvalid;
        logic        rvalid;
        logic [2:0]  tfAddr;
        logic [15:0] tfWrData;
        logic        tfWr;
        logic        tfRd;
        logic        dmack;
    } aw_hreg_t;

    aw_hreg_t r_ff;
    aw_hreg_t nxt_r;
    logic     tfHit;

    assign tfHit   = (r_ff.addr[7:5] == HREG_TF_PAGE) && (r_ff.addr[1:0] == 2'b00);
    assign awready = (r_ff.st == HS_IDLE) && !r_ff.awGot;
    assign wready  = (r_ff.st == HS_IDLE) && !r_ff.wGot;
    // writes have priority over reads
    assign arready = (r_ff.st == HS_IDLE) && !r_ff.awGot && !r_ff.wGot && !awvalid && !wvalid;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.tfWr = 1'b0;
        nxt_r.tfRd = 1'b0;
        nxt_r.dmack = 1'b0;
        unique case (r_ff.st)
            HS_IDLE: begin
                if (awvalid && awready) begin
                    nxt_r.awGot = 1'b1;
                    nxt_r.addr = awaddr;
                end
                if (wvalid && wready) begin
                    nxt_r.wGot = 1'b1;
                    nxt_r.data = wdata[15:0];
                end
                if (r_ff.awGot && r_ff.wGot) begin
                    nxt_r.isRd = 1'b0;
                    nxt_r.st = HS_LINK;
                end else if (arvalid && arready) begin
                    nxt_r.addr = araddr;
                    nxt_r.isRd = 1'b1;
                    nxt_r.st = HS_LINK;
                end
            end
            HS_LINK: begin
                nxt_r.resp = RESP_OKAY;
                if (r_ff.isRd) begin
                    if (r_ff.addr == HREG_STATUS) begin
                        nxt_r.rdata = {29'h0, link.dmareq, link.intrq, 1'b0};
                        nxt_r.rvalid = 1'b1;
                        nxt_r.st = HS_RESP;
                    end else if (tfHit) begin
                        nxt_r.tfRd = 1'b1;
                        nxt_r.tfAddr = r_ff.addr[4:2];
                        nxt_r.rdWait = 1'b0;
                        nxt_r.st = HS_WAIT;
                    end else begin
                        nxt_r.rdata = 32'h0;
                        nxt_r.resp = RESP_SLVERR;
                        nxt_r.rvalid = 1'b1;
                        nxt_r.st = HS_RESP;
                    end
                end else if (r_ff.addr == HREG_DMA) begin
                    // word waits here until the card requests
                    if (link.dmareq) begin
                        nxt_r.dmack = 1'b1;
                        nxt_r.tfWr = 1'b1;
                        nxt_r.tfWrData = r_ff.data;
                        nxt_r.bvalid = 1'b1;
                        nxt_r.st = HS_RESP;
                    end
                end else if (tfHit) begin
                    nxt_r.tfWr = 1'b1;
                    nxt_r.tfAddr = r_ff.addr[4:2];
                    nxt_r.tfWrData = r_ff.data;
                    if (r_ff.addr[4:2] == TF_HEAD) begin
                        nxt_r.tfWrData = r_ff.data | {8'h00, HEAD_FIXED};
                    end
                    nxt_r.bvalid = 1'b1;
                    nxt_r.st = HS_RESP;
                end else begin
                    nxt_r.resp = RESP_SLVERR;
                    nxt_r.bvalid = 1'b1;
                    nxt_r.st = HS_RESP;
                end
            end
            HS_WAIT: begin
                nxt_r.rdWait = 1'b1;
                if (r_ff.rdWait) begin
                    nxt_r.rdata = {16'h0000, link.tfRdData};
                    nxt_r.rvalid = 1'b1;
                    nxt_r.st = HS_RESP;
                end
            end
            HS_RESP: begin
                if ((r_ff.bvalid && bready) || (r_ff.rvalid && rready)) begin
                    nxt_r.bvalid = 1'b0;
                    nxt_r.rvalid = 1'b0;
                    nxt_r.awGot = 1'b0;
                    nxt_r.wGot = 1'b0;
                    nxt_r.st = HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign bresp         = r_ff.resp;
    assign bvalid        = r_ff.bvalid;
    assign rdata         = r_ff.rdata;
    assign rresp         = r_ff.resp;
    assign rvalid        = r_ff.rvalid;
    assign link.tfAddr   = r_ff.tfAddr;
    assign link.tfWrData = r_ff.tfWrData;
    assign link.tfWr     = r_ff.tfWr;
    assign link.tfRd     = r_ff.tfRd;
    assign link.dmack    = r_ff.dmack;
endmodule

// ===== testbench/aw_link_sva.sv
`timescale 1ns/1ps
module aw_link_sva
    import aw_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [2:0]  tfAddr,
    input wire logic [15:0] tfWrData,
    input wire logic        tfWr,
    input wire logic        tfRd,
    input wire logic        dmack,
    input wire logic [15:0] tfRdData,
    input wire logic        intrq,
    input wire logic        dmareq
);
    logic statRd;
    logic cmdWr;
    assign statRd = tfRd && tfAddr == TF_CMD;
    assign cmdWr  = tfWr && !dmack && tfAddr == TF_CMD;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_ack_strobe: assert property (dmack |-> tfWr)
        else $error("dma acknowledge without strobe");
    chk_ack_req: assert property (dmack |-> $past(dmareq))
        else $error("dma word without request");
    chk_strobe_pulse: assert property (tfWr |=> !tfWr)
        else $error("write strobe longer than one cycle");
    chk_head_bits: assert property (tfWr && !dmack && tfAddr == TF_HEAD |-> tfWrData[7] && tfWrData[5])
        else $error("head write without fixed bits");
    chk_req_word: assert property ($fell(dmareq) |-> $past(dmack))
        else $error("dma request dropped with no word");
    chk_intr_dma: assert property ($rose(intrq) |-> !dmareq)
        else $error("interrupt during dma transfer");
    chk_cmd_clear: assert property (cmdWr |=> !intrq)
        else $error("command left interrupt set");
    chk_intr_cause: assert property ($fell(intrq) |-> $past(statRd) || $past(cmdWr))
        else $error("interrupt cleared without cause");
    chk_nop_done: assert property (cmdWr && tfWrData[7:0] == CMD_TRANSLATE |-> ##[2:8] intrq)
        else $error("no-op not completed in time");
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb
    import aw_pkg::*;
();
    logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready, mediaErr;
    logic        awready, wready, bvalid, arready, rvalid, sectorValid;
    logic [7:0]  awaddr, araddr, bufRdAddr, rb;
    logic [31:0] wdata, rdata, rdv;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] bufRdData;
    logic [27:0] sectorLba, lastLba;
    int          err_count, checked, svCount, svKeep;
    aw_link_if aw_link_if_inst();
    aw_host_end aw_host_end_inst (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .link(aw_link_if_inst.host));
    aw_dev_end aw_dev_end_inst (.clk(clk), .nrst(nrst), .link(aw_link_if_inst.dev),
        .bufRdAddr(bufRdAddr), .bufRdData(bufRdData), .sectorValid(sectorValid),
        .sectorLba(sectorLba), .mediaErr(mediaErr));
    aw_link_sva aw_link_sva_inst (.clk(clk), .nrst(nrst), .tfAddr(aw_link_if_inst.tfAddr),
        .tfWrData(aw_link_if_inst.tfWrData), .tfWr(aw_link_if_inst.tfWr),
        .tfRd(aw_link_if_inst.tfRd), .dmack(aw_link_if_inst.dmack),
        .tfRdData(aw_link_if_inst.tfRdData), .intrq(aw_link_if_inst.intrq),
        .dmareq(aw_link_if_inst.dmareq));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (sectorValid === 1'b1) begin
            svCount++;
            lastLba = sectorLba;
        end
    end
    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        err_count++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask
    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
    endtask
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) fail($sformatf("word %h, expected %h", got, exp));
    endtask
    task automatic ax(input bit wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        if (wr) begin
            awaddr <= a;
            wdata <= {16'h0000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        // no local limit: only the watchdog ends a wait
        forever begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (wr ? bvalid === 1'b1 : rvalid === 1'b1) break;
        end
        rsp = wr ? bresp : rresp;
        rdv = rdata;
        rb = rdata[7:0];
        bready <= 1'b0;
        rready <= 1'b0;
    endtask
    task automatic tfW(input logic [2:0] i, input logic [15:0] v);
        ax(1'b1, 8'h20 | {3'h0, i, 2'b00}, v);
    endtask
    task automatic tfR(input logic [2:0] i);
        ax(1'b0, 8'h20 | {3'h0, i, 2'b00}, 16'h0000);
    endtask
    task automatic setAddr(input logic [27:0] lba);
        tfW(TF_SEC, {8'h00, lba[7:0]});
        tfW(TF_CYLL, {8'h00, lba[15:8]});
        tfW(TF_CYLH, {8'h00, lba[23:16]});
        tfW(TF_HEAD, {12'h000, lba[27:24]});
    endtask
    task automatic issue(input logic [7:0] cmd, input logic [7:0] cnt, input logic [7:0] ft);
        tfW(TF_CNT, {8'h00, cnt});
        tfW(TF_ERR, {8'h00, ft});
        tfW(TF_CMD, {8'h00, cmd});
    endtask
    // poll status page (tf=0) or task-file status (tf=1)
    task automatic waitBit(input bit tf, input int b);
        int n;
        n = 0;
        do begin
            ax(1'b0, tf ? 8'h3c : HREG_STATUS, 16'h0000);
            n++;
        end while (rdv[b] !== 1'b1 && n < 300);
        if (rdv[b] !== 1'b1) fail("flag never set");
    endtask
    task automatic fin(input logic [7:0] st, input logic [7:0] er);
        waitBit(1'b0, 1);
        tfR(TF_CMD);
        chkByte(rb, st);
        if (st[0]) begin
            tfR(TF_ERR);
            chkByte(rb, er);
        end
    endtask
    task automatic sector(input bit dma, input logic [15:0] seed);
        for (int i = 0; i < 256; i++) begin
            if (dma) ax(1'b1, HREG_DMA, seed + 16'(i));
            else tfW(TF_DATA, seed + 16'(i));
        end
    endtask
    task automatic bufChk(input logic [7:0] a, input logic [15:0] exp);
        bufRdAddr <= a;
        repeat (2) @(posedge clk);
        chkWord({16'h0000, bufRdData}, {16'h0000, exp});
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fail("watchdog expired");
        complete_run();
    end
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, mediaErr} = '0;
        {awaddr, araddr, bufRdAddr, wdata} = '0;
        err_count = 0;
        checked = 0;
        svCount = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        ax(1'b1, 8'h08, 16'h0000);
        chkByte({6'h00, rsp}, {6'h00, RESP_SLVERR});
        ax(1'b0, 8'h10, 16'h0000);
        chkWord({rdv[29:0], rsp}, {30'h0, RESP_SLVERR});
        issue(CMD_WRMULT, 8'h02, 8'h00);
        fin(8'h51, ERR_ABRT);
        for (int k = 0; k < 2; k++) begin
            issue(k ? CMD_WEARLEVEL : CMD_TRANSLATE, 8'h05, 8'h00);
            fin(8'h50, 8'h00);
            tfR(TF_CNT);
            chkByte(rb, 8'h00);
        end
        issue(CMD_SETMULT, 8'h02, 8'h00);
        fin(8'h51, ERR_ABRT);
        issue(CMD_SETMULT, 8'h00, 8'h00);
        fin(8'h50, 8'h00);
        issue(CMD_WRMULT, 8'h01, 8'h00);
        fin(8'h51, ERR_ABRT);
        issue(CMD_SETFEAT, 8'h00, FEAT_8BIT_ON);
        fin(8'h50, 8'h00);
        issue(CMD_WRDMA, 8'h01, 8'h00);
        fin(8'h51, ERR_ABRT);
        issue(CMD_SETFEAT, 8'h00, FEAT_8BIT_OFF);
        fin(8'h50, 8'h00);
        setAddr(28'h5302010);
        issue(CMD_WRDMA, 8'h02, 8'h00);
        waitBit(1'b0, 2);
        sector(1'b1, 16'h0100);
        ax(1'b0, HREG_STATUS, 16'h0000);
        chkByte({7'h00, rdv[1]}, 8'h00);
        sector(1'b1, 16'h0200);
        fin(8'h50, 8'h00);
        tfR(TF_SEC);
        chkByte(rb, 8'h11);
        chkWord(svCount, 32'd2);
        chkWord({4'h0, lastLba}, 32'h05302011);
        bufChk(8'h07, 16'h0207);
        mediaErr <= 1'b1;
        setAddr(28'h5302030);
        issue(CMD_WRDMA, 8'h02, 8'h00);
        sector(1'b1, 16'h0300);
        fin(8'h51, ERR_MEDIA);
        mediaErr <= 1'b0;
        tfR(TF_SEC);
        chkByte(rb, 8'h30);
        ax(1'b0, HREG_STATUS, 16'h0000);
        chkByte({7'h00, rdv[2]}, 8'h00);
        issue(CMD_SETMULT, 8'h01, 8'h00);
        fin(8'h50, 8'h00);
        setAddr(28'h5302040);
        issue(CMD_WRMULT, 8'h03, 8'h00);
        repeat (10) @(posedge clk);
        ax(1'b0, HREG_STATUS, 16'h0000);
        chkByte({7'h00, rdv[1]}, 8'h00);
        waitBit(1'b1, 3);
        sector(1'b0, 16'h0400);
        repeat (3) @(posedge clk);
        mediaErr <= 1'b1;
        waitBit(1'b0, 1);
        waitBit(1'b1, 3);
        sector(1'b0, 16'h0500);
        fin(8'h51, ERR_MEDIA);
        mediaErr <= 1'b0;
        tfR(TF_CNT);
        chkByte(rb, 8'h02);
        tfR(TF_SEC);
        chkByte(rb, 8'h41);
        svKeep = svCount;
        issue(CMD_WRBUF, 8'h00, 8'h00);
        waitBit(1'b1, 3);
        sector(1'b0, 16'h1000);
        fin(8'h50, 8'h00);
        chkWord(svCount, svKeep);
        bufChk(8'hff, 16'h10ff);
        complete_run();
    end
endmodule
